// ### rrtg_pkg.sv
/*
  Shared constants and types of the braking resistor thermal guard:
  parameter offsets, accepted ranges, reset values, timing and state types.
  Assumes a 20 MHz core clock and a 1 ms thermal sample interval.
*/
`default_nettype none

package rrtg_pkg;

  // Parameter offsets
  localparam logic [15:0] OFS_POWER    = 16'h02de;
  localparam logic [15:0] OFS_OHMS     = 16'h02e2;
  localparam logic [15:0] OFS_TAU      = 16'h02e4;
  localparam logic [15:0] OFS_SELECT   = 16'h02e6;
  localparam logic [15:0] OFS_LIMIT    = 16'h02e8;

  // Accepted ranges, time constant in units of 0.1 s
  localparam logic [31:0] OHMS_MAX     = 32'h0000_00ff;
  localparam logic [31:0] TAU_MIN      = 32'h0000_0001;
  localparam logic [31:0] TAU_MAX      = 32'h0000_2ee0;
  localparam logic [31:0] LIMIT_MAX    = 32'h0000_f230;
  localparam logic [7:0]  SEL_EXTERNAL = 8'hff;
  localparam logic [7:0]  SEL_INTERNAL = 8'h00;

  // Reset values
  localparam logic [15:0] OHMS_RST     = 16'h0000;
  localparam logic [31:0] TAU_RST      = 32'h0000_03e8;
  localparam logic [7:0]  SEL_RST      = 8'h00;
  localparam logic [15:0] LIMIT_RST    = 16'h03e8;

  // Internal resistor figures, plain defaults
  localparam logic [15:0] INT_OHMS     = 16'h0021;
  localparam logic [15:0] INT_LIMIT    = 16'h00c8;

  // Timing
  localparam int          CLK_NS       = 50;
  localparam int          SAMPLE_US    = 1000;
  localparam int          TICK_CYCLES  = SAMPLE_US * 1000 / CLK_NS;

  // Filter coefficient numerator: ln3 * Ts[s] * 10 * 2^28, so that a step
  // to 150 % of the limit crosses it one time constant later
  localparam longint      LN3_Q16      = 71999;
  localparam logic [31:0] COEF_NUM     =
    32'((64'(LN3_Q16) * 64'd4096 * 64'(SAMPLE_US)) / 64'd100000);
  localparam logic [23:0] COEF_RST     = 24'(COEF_NUM / TAU_RST);
  localparam int          COEF_SHIFT   = 28;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_FILT = 2'b10
  } rrtg_fsm_type;

  typedef struct packed {
    logic [15:0] ext_ohms;
    logic [31:0] tau;
    logic [7:0]  sel;
    logic [15:0] limit;
  } rrtg_cfg_type;

  typedef struct packed {
    rrtg_cfg_type cfg;
    rrtg_fsm_type fsm;
    logic [15:0]  tick_cnt;
    logic [31:0]  power_x;
    logic [47:0]  filt_y;
    logic [23:0]  coef;
    logic         coef_go;
    logic         pdiv_go;
    logic         fault;
    logic [7:0]   duty_out;
    logic [31:0]  rdata;
  } rrtg_state_type;

endpackage : rrtg_pkg

`default_nettype wire

// ### rrtg_divider.sv
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse; a start while busy drops the running
  division and begins anew, so only the newest operands give a result.
  A zero divisor yields an all-ones quotient.
*/
`timescale 1ns/10ps
`default_nettype none

module rrtg_divider #(
  parameter int NW = 40,
  parameter int DW = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Operation
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               done,
  output logic [NW-1:0]      quo
);

  typedef struct packed {
    logic [NW-1:0] quo;
    logic [DW-1:0] rem;
    logic [DW-1:0] den;
    logic [7:0]    cnt;
    logic          busy;
    logic          done;
  } rrtg_div_st_type;

  rrtg_div_st_type s_r;
  rrtg_div_st_type s_nxt;
  logic [DW:0]     trial;
  logic            ge;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    trial = {s_r.rem, s_r.quo[NW-1]};
    ge = (trial >= {1'b0, s_r.den});
    // Restart rather than ignore, so a late operand change is never lost
    if (start) begin
      s_nxt.quo  = num;
      s_nxt.rem  = '0;
      s_nxt.den  = den;
      s_nxt.cnt  = 8'(NW);
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      s_nxt.rem = ge ? DW'(trial - {1'b0, s_r.den}) : trial[DW-1:0];
      s_nxt.quo = {s_r.quo[NW-2:0], ge};
      s_nxt.cnt = s_r.cnt - 8'h01;
      if (s_r.cnt == 8'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign quo  = s_r.quo;

endmodule : rrtg_divider

`default_nettype wire

// ### rrtg_guard.sv
/*
  Braking resistor thermal guard: computes resistor power each sample,
  low-pass filters it and raises an overload fault above the limit.
  Assumes synchronous inputs, a 20 MHz core clock and a simple
  parameter port (address, write strobe, registered read data).
*/
`timescale 1ns/10ps
`default_nettype none

module rrtg_guard #(
  parameter int TICK_CYCLES = rrtg_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Power stage
  input  wire logic [15:0] bus_voltage,
  input  wire logic [7:0]  duty_in,
  output logic [7:0]       duty_out,
  output logic             fault,
  // Parameter port
  input  wire logic [15:0] param_addr,
  input  wire logic        param_we,
  input  wire logic [31:0] param_wdata,
  output logic [31:0]      param_rdata
);

  logic                    rst_meta_r;
  logic                    rst_n;
  rrtg_pkg::rrtg_state_type s_r;
  rrtg_pkg::rrtg_state_type s_nxt;
  logic                    ext_sel;
  logic [15:0]             limit_w;
  logic [15:0]             den_w;
  logic [39:0]             pnum_w;
  logic                    pdiv_done;
  logic [39:0]             pdiv_quo;
  logic                    cdiv_done;
  logic [31:0]             cdiv_quo;
  logic signed [48:0]      diff_w;
  logic signed [73:0]      prod_w;
  logic signed [48:0]      ynew_w;

  // Reset is released through two flops so all state leaves reset together
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  assign ext_sel = (s_r.cfg.sel == rrtg_pkg::SEL_EXTERNAL);
  assign limit_w = ext_sel ? s_r.cfg.limit : rrtg_pkg::INT_LIMIT;
  assign den_w   = ext_sel ? s_r.cfg.ext_ohms : rrtg_pkg::INT_OHMS;
  // Applied duty is used, so a forced-off resistor cools in the model
  assign pnum_w  = 40'(32'(bus_voltage) * 32'(bus_voltage)) * 40'(s_r.duty_out);

  rrtg_divider #(.NW(40), .DW(16)) u_pdiv (
    .clk   (core_clk),
    .rst_n (rst_n),
    .start (s_r.pdiv_go),
    .num   (pnum_w),
    .den   (den_w),
    .done  (pdiv_done),
    .quo   (pdiv_quo)
  );

  rrtg_divider #(.NW(32), .DW(16)) u_cdiv (
    .clk   (core_clk),
    .rst_n (rst_n),
    .start (s_r.coef_go),
    .num   (rrtg_pkg::COEF_NUM),
    .den   (s_r.cfg.tau[15:0]),
    .done  (cdiv_done),
    .quo   (cdiv_quo)
  );

  // y += (x - y) * coef / 2^28, y held in watts with 16 fraction bits
  assign diff_w = $signed({1'b0, s_r.power_x, 16'h0000}) - $signed({1'b0, s_r.filt_y});
  assign prod_w = 74'(diff_w * $signed({1'b0, s_r.coef}));
  assign ynew_w = $signed({1'b0, s_r.filt_y}) + 49'(prod_w >>> rrtg_pkg::COEF_SHIFT);

  always_comb begin
    s_nxt = s_r;
    s_nxt.coef_go = 1'b0;
    s_nxt.pdiv_go = 1'b0;
    // Out-of-range writes are dropped, the old setting stays
    if (param_we) begin
      case (param_addr)
        rrtg_pkg::OFS_OHMS: begin
          if (param_wdata <= rrtg_pkg::OHMS_MAX) begin
            s_nxt.cfg.ext_ohms = param_wdata[15:0];
          end
        end
        rrtg_pkg::OFS_TAU: begin
          if (param_wdata >= rrtg_pkg::TAU_MIN && param_wdata <= rrtg_pkg::TAU_MAX) begin
            s_nxt.cfg.tau = param_wdata;
            s_nxt.coef_go = 1'b1;
          end
        end
        rrtg_pkg::OFS_SELECT: begin
          if (param_wdata[7:0] == rrtg_pkg::SEL_EXTERNAL ||
              param_wdata[7:0] == rrtg_pkg::SEL_INTERNAL) begin
            s_nxt.cfg.sel = param_wdata[7:0];
          end
        end
        rrtg_pkg::OFS_LIMIT: begin
          if (param_wdata <= rrtg_pkg::LIMIT_MAX) begin
            s_nxt.cfg.limit = param_wdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (cdiv_done) begin
      s_nxt.coef = cdiv_quo[23:0];
    end
    case (s_r.fsm)
      rrtg_pkg::ST_IDLE: begin
        if (s_r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
          s_nxt.tick_cnt = 16'h0000;
          s_nxt.pdiv_go  = 1'b1;
          s_nxt.fsm      = rrtg_pkg::ST_DIV;
        end else begin
          s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
        end
      end
      rrtg_pkg::ST_DIV: begin
        s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
        if (pdiv_done) begin
          // Quotient over 256 removes the duty scale and always fits 32 bits
          s_nxt.power_x = pdiv_quo[39:8];
          s_nxt.fsm = rrtg_pkg::ST_FILT;
        end
      end
      rrtg_pkg::ST_FILT: begin
        s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
        s_nxt.filt_y   = ynew_w[48] ? 48'h0 : ynew_w[47:0];
        s_nxt.fsm      = rrtg_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.fsm = rrtg_pkg::ST_IDLE;
      end
    endcase
    s_nxt.fault    = (s_r.filt_y[47:16] > 32'(limit_w));
    s_nxt.duty_out = s_r.fault ? 8'h00 : duty_in;
    case (param_addr)
      rrtg_pkg::OFS_POWER:  s_nxt.rdata = s_r.power_x;
      rrtg_pkg::OFS_OHMS:   s_nxt.rdata = 32'(s_r.cfg.ext_ohms);
      rrtg_pkg::OFS_TAU:    s_nxt.rdata = s_r.cfg.tau;
      rrtg_pkg::OFS_SELECT: s_nxt.rdata = 32'(s_r.cfg.sel);
      rrtg_pkg::OFS_LIMIT:  s_nxt.rdata = 32'(s_r.cfg.limit);
      default:              s_nxt.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r              <= '0;
      s_r.cfg.ext_ohms <= rrtg_pkg::OHMS_RST;
      s_r.cfg.tau      <= rrtg_pkg::TAU_RST;
      s_r.cfg.sel      <= rrtg_pkg::SEL_RST;
      s_r.cfg.limit    <= rrtg_pkg::LIMIT_RST;
      s_r.coef         <= rrtg_pkg::COEF_RST;
      s_r.fsm          <= rrtg_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign duty_out    = s_r.duty_out;
  assign fault       = s_r.fault;
  assign param_rdata = s_r.rdata;

  // Checks
  localparam int DIV_BOUND = 60;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_duty_forced: assert property (fault |=> duty_out == 8'h00)
    else $error("duty not forced to zero under fault");
  chk_fault_cause: assert property ($rose(fault)
      |-> $past(s_r.filt_y[47:16] > 32'(limit_w)))
    else $error("fault rose without filtered power above limit");
  chk_ohms_range: assert property (s_r.cfg.ext_ohms <= 16'h00ff)
    else $error("external resistance out of range");
  chk_tau_range: assert property (s_r.cfg.tau >= rrtg_pkg::TAU_MIN
      && s_r.cfg.tau <= rrtg_pkg::TAU_MAX)
    else $error("time constant out of range");
  chk_select_codes: assert property (s_r.cfg.sel == 8'h00 || s_r.cfg.sel == 8'hff)
    else $error("selector holds an illegal code");
  // Internal resistor must fault on its own limit whatever the external one says
  chk_limit_source: assert property (!ext_sel
      && s_r.filt_y[47:16] > 32'(rrtg_pkg::INT_LIMIT) |=> fault)
    else $error("internal limit not applied with internal resistor");
  chk_power_bounded: assert property ($rose(s_r.fsm == rrtg_pkg::ST_DIV)
      |-> ##[1:DIV_BOUND] s_r.fsm == rrtg_pkg::ST_FILT)
    else $error("power update did not finish in time");
  chk_tau_coef: assert property (param_we && param_addr == rrtg_pkg::OFS_OHMS
      |=> $stable(s_r.coef) || $past(cdiv_done))
    else $error("coefficient moved without a time constant update");
  chk_filter_rise: assert property (s_r.fsm == rrtg_pkg::ST_FILT
      && s_r.power_x > s_r.filt_y[47:16] |=> s_r.filt_y >= $past(s_r.filt_y))
    else $error("filter fell while input above output");

  cov_fault_raised: cover property ($rose(fault));
  cov_ext_tick: cover property (ext_sel && s_r.fsm == rrtg_pkg::ST_FILT);
  cov_tau_write: cover property (cdiv_done);
  cov_fault_clear: cover property ($fell(fault));

endmodule : rrtg_guard

`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for the braking resistor thermal guard.
  Assumes rrtg_pkg and the design files are compiled first; a short
  sample tick keeps the time to fault within a few tens of thousands of cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;

  localparam int TICK = 100;

  logic        core_clk = 1'b0;
  logic        resetn;
  logic [15:0] bus_voltage;
  logic [7:0]  duty_in;
  logic [7:0]  duty_out;
  logic        fault;
  logic [15:0] param_addr;
  logic        param_we;
  logic [31:0] param_wdata;
  logic [31:0] param_rdata;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          waited;

  rrtg_guard #(.TICK_CYCLES(TICK)) u_rrtg_guard (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .bus_voltage (bus_voltage),
    .duty_in     (duty_in),
    .duty_out    (duty_out),
    .fault       (fault),
    .param_addr  (param_addr),
    .param_we    (param_we),
    .param_wdata (param_wdata),
    .param_rdata (param_rdata)
  );

  always #25 core_clk = ~core_clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Cuts a hang short; the whole run needs about 11000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    @(negedge core_clk);
    param_addr  = addr;
    param_wdata = data;
    param_we    = 1'b1;
    @(negedge core_clk);
    param_we    = 1'b0;
  endtask : wr

  // Read data is registered, so it is looked at one full cycle later
  task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
    @(negedge core_clk);
    param_addr = addr;
    @(negedge core_clk);
    chk(param_rdata, exp);
  endtask : rd

  // Bounded wait for the fault level; returns cycles waited
  task automatic wait_fault(input logic lvl, input int maxc, output int n);
    n = 0;
    while (fault !== lvl && n < maxc) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_fault

  // Range table, refused and accepted writes: address, written value, value read back afterwards
  logic [15:0] t_addr [12] = '{16'h02e2, 16'h02e2, 16'h02e4, 16'h02e4, 16'h02e4, 16'h02e4,
                               16'h02e6, 16'h02e6, 16'h02e6, 16'h02e8, 16'h02e8, 16'h02de};
  logic [31:0] t_data [12] = '{32'h0000_0100, 32'h0000_00ff, 32'h0000_0000, 32'h0000_2ee1,
                               32'h0000_2ee0, 32'h0000_0001, 32'h0000_0001, 32'h0000_00ff,
                               32'h0000_0000, 32'h0000_f231, 32'h0000_f230, 32'h0000_1234};
  logic [31:0] t_exp  [12] = '{32'h0000_0000, 32'h0000_00ff, 32'h0000_03e8, 32'h0000_03e8,
                               32'h0000_2ee0, 32'h0000_0001, 32'h0000_0000, 32'h0000_00ff,
                               32'h0000_0000, 32'h0000_03e8, 32'h0000_f230, 32'h0000_0000};

  initial begin
    resetn      = 1'b0;
    bus_voltage = 16'h0000;
    duty_in     = 8'h00;
    param_addr  = 16'h0000;
    param_we    = 1'b0;
    param_wdata = 32'h0000_0000;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    rd(16'h02e2, 32'h0000_0000);
    rd(16'h02e4, 32'h0000_03e8);
    rd(16'h02e6, 32'h0000_0000);
    rd(16'h02e8, 32'h0000_03e8);
    rd(16'h02de, 32'h0000_0000);
    rd(16'h02e0, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      wr(t_addr[i], t_data[i]);
      rd(t_addr[i], t_exp[i]);
    end
    // 120 V, 16 ohm, half duty gives 450 W: 150 % of a 300 W limit
    wr(16'h02e2, 32'h0000_0010);
    wr(16'h02e8, 32'h0000_012c);
    wr(16'h02e6, 32'h0000_00ff);
    @(negedge core_clk);
    bus_voltage = 16'h0078;
    duty_in     = 8'h80;
    repeat (3 * TICK) @(negedge core_clk);
    rd(16'h02de, 32'h0000_01c2);
    chk({24'h00_0000, duty_out}, 32'h0000_0080);
    // Time constant 0.1 s is 100 samples; about 300 cycles already gone
    wait_fault(1'b1, 12000, waited);
    chk({31'h0, (waited >= 9000 && waited <= 10800)}, 32'h0000_0001);
    @(negedge core_clk);
    chk({24'h00_0000, duty_out}, 32'h0000_0000);
    // Raising the limit clears the level fault without any latch
    wr(16'h02e8, 32'h0000_f230);
    wait_fault(1'b0, 10, waited);
    chk({31'h0, fault}, 32'h0000_0000);
    @(negedge core_clk);
    chk({24'h00_0000, duty_out}, 32'h0000_0080);
    // Doubling the resistance halves the power
    wr(16'h02e2, 32'h0000_0020);
    repeat (2 * TICK) @(negedge core_clk);
    rd(16'h02de, 32'h0000_00e1);
    // Internal resistor ignores the high external limit and faults
    wr(16'h02e6, 32'h0000_0000);
    wait_fault(1'b1, 5 * TICK, waited);
    chk({31'h0, fault}, 32'h0000_0001);
    conclude();
  end

endmodule : tb

`default_nettype wire
